// >>> shared/codec_irq_pkg.sv
// Purpose: constants and types of the interrupt status block
// Assumes: 16-bit registers reached at their word addresses
// Notes:   named constants; the design also writes level codes 0D to 0F as literals
package codec_irq_pkg;
	// -----------------------------------------------------------
	// Register addresses
	// -----------------------------------------------------------
	localparam logic [15:0] ADDR_PIN6_CFG    = 16'h0205;
	localparam logic [15:0] ADDR_FLAGS_GPIO  = 16'h0230;
	localparam logic [15:0] ADDR_FLAGS_SYS   = 16'h0231;
	localparam logic [15:0] ADDR_MASK_GPIO   = 16'h0238;
	localparam logic [15:0] ADDR_MASK_SYS    = 16'h0239;
	localparam logic [15:0] ADDR_DEBOUNCE    = 16'h0248;
	// -----------------------------------------------------------
	// Field layouts and reset values
	// -----------------------------------------------------------
	localparam int          POS_PIN6_FLAG    = 5;
	localparam int          POS_PIN5_FLAG    = 4;
	localparam logic [15:0] GPIO_FLAG_BITS   = 16'h0030;
	localparam logic [15:0] SYS_FLAG_BITS    = 16'hFFED;
	localparam logic [15:0] FLAGS_RST        = 16'h0000;
	localparam logic [15:0] MASK_GPIO_RST    = 16'h0030;
	localparam logic [15:0] MASK_SYS_RST     = 16'hFFFF;
	localparam logic [15:0] DB_EN_BITS       = 16'h003F;
	localparam logic [15:0] DB_EN_RST        = 16'h003F;
	localparam logic [15:0] DB_SRC_BITS      = 16'h002D;
	localparam logic [4:0]  FN_RST           = 5'h00;
	// -----------------------------------------------------------
	// Pin 6 function codes
	// -----------------------------------------------------------
	localparam logic [4:0] FN_IRQ        = 5'h03;
	localparam logic [4:0] FN_OVERHEAT   = 5'h04;
	localparam logic [4:0] FN_PLL2       = 5'h06;
	localparam logic [4:0] FN_PLL3       = 5'h07;
	localparam logic [4:0] FN_FLL        = 5'h09;
	localparam logic [4:0] FN_RANGE      = 5'h0A;
	localparam logic [4:0] FN_SEQ        = 5'h0B;
	localparam logic [4:0] FN_LVL_FIRST  = 5'h0C;
	localparam logic [4:0] FN_LVL_LAST   = 5'h10;
	localparam logic [4:0] FN_FIFO       = 5'h11;
	localparam logic [4:0] FN_OUT_CLK    = 5'h12;
	localparam logic [4:0] FN_DMIC_CLK   = 5'h13;
	localparam logic [4:0] FN_DMIC_DATA  = 5'h14;
	localparam logic [4:0] FN_MIC_DET    = 5'h15;
	localparam logic [4:0] FN_MIC_SHORT  = 5'h16;
	// -----------------------------------------------------------
	// Timing
	// -----------------------------------------------------------
	localparam int         CLK_PERIOD_NS = 100;
	localparam int         DB_TIME_NS    = 1000;
	localparam int         DB_CYC_INT    =
		(DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] DB_LAST       = 8'(DB_CYC_INT - 1);
	// -----------------------------------------------------------
	// Event sources, laid out as the system flag register
	// -----------------------------------------------------------
	typedef struct packed {
		logic mic_short;
		logic mic_detect;
		logic fifo_error;
		logic level_lock;
		logic level_threshold;
		logic level_saturation;
		logic peak_overload;
		logic noise_gate;
		logic sequencer_done;
		logic range_activity;
		logic freq_loop_lock;
		logic spare4;
		logic third_pll_lock;
		logic second_pll_lock;
		logic spare1;
		logic overheat;
	} sys_evt_t;
endpackage

// >>> design/codec_irq.sv
// Purpose: interrupt flags, masks and pin 6 routing
// Assumes: event sources are asynchronous levels
// Notes:   flags set on a rising source level
//
// Operation
// - Flags sticky, cleared by writing one
// - Pin flags at bits 5 and 4
// - Mic short bit 15, detect 14
// - FIFO error flag at bit 13
// - Level control flags at bits 12..8
// - Sequencer done flag at bit 7
// - Range controller activity at bit 6
// - Loop lock 5, PLL locks 3, 2
// - Overheat flag at bit 0
// - All flags reset to zero
// - Mask per flag, one masks, resets one
// - System mask bits match flag positions
// - Pin 6 codes select event outputs
// - Codes route clocks and mic data
// - Codes drive mic detect, short levels
// - PLL, loop lock, overheat sources debounced
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module codec_irq
	import codec_irq_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire sys_evt_t    events_i,
	input  wire logic        pin5_i,
	input  wire logic        pin6_i,
	output logic             pin6_o,
	output logic             pin6_oe_o,
	input  wire logic        output_clock_i,
	input  wire logic        dmic_clk_i,
	output logic             dmic_data_o,
	output logic             irq_o
);
	// -----------------------------------------------------------
	// Address decode
	// -----------------------------------------------------------
	// Exact word match on the register port
	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] off);
		hit = (a == off);
	endfunction

	// -----------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------
	logic [17:0] raw;            // Pins and sources together
	logic [17:0] sync1_r;        // First stage, read only below
	logic [17:0] sync2_r;        // Safe synchronised levels
	logic [15:0] lvl;            // Source levels after debounce
	logic [17:0] lvl_all;        // Sources plus pin levels
	logic [17:0] prev_r;         // Last levels, for edges
	logic [17:0] rise;           // Rising edges this cycle
	logic [15:0] st_gpio_r;      // Pin flag register
	logic [15:0] st_sys_r;       // System flag register
	logic [15:0] mask_gpio_r;    // Pin mask register
	logic [15:0] mask_sys_r;     // System mask register
	logic [15:0] dben_r;         // Debounce enables
	logic [4:0]  fn_r;           // Pin 6 function select
	logic [15:0] set_gpio;       // Pin flag set terms
	logic [15:0] set_sys;        // System flag set terms
	logic [15:0] clr_gpio;       // Pin flag clear terms
	logic [15:0] clr_sys;        // System flag clear terms
	logic        pend;           // Any unmasked flag
	logic        p6_val;         // Pin 6 output value
	logic        p6_oe;          // Pin 6 output enable
	logic [15:0] rd_val;         // Read mux value
	logic [15:0] rdata_r;        // Read data register
	logic        irq_r;          // Interrupt register
	logic        pin6_r;         // Pin 6 output register
	logic        pin6_oe_r;      // Pin 6 enable register
	logic        dmic_r;         // Mic data register

	// -----------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------
	assign raw = {pin6_i, pin5_i, events_i};
	// Two stages; the first one feeds only the second
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= raw;
			sync2_r <= sync1_r;
		end
	end

	// -----------------------------------------------------------
	// Debounce of lock and overheat sources
	// -----------------------------------------------------------
	// A source level is taken only after it has differed from
	// the held level for the full debounce time; glitches on a
	// lock line then never raise a flag
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_src
			if (DB_SRC_BITS[gi]) begin : g_db
				logic [7:0] cnt_r;   // Cycles of difference
				logic       stab_r;  // Held stable level
				always_ff @(posedge clock_i) begin
					if (!nrst_i) begin
						cnt_r  <= 8'h00;
						stab_r <= 1'b0;
					end else if (!dben_r[gi]) begin
						// Filter off: follow the source
						cnt_r  <= 8'h00;
						stab_r <= sync2_r[gi];
					end else if (sync2_r[gi] == stab_r) begin
						cnt_r  <= 8'h00;
					end else if (cnt_r == DB_LAST) begin
						// Held long enough: accept
						cnt_r  <= 8'h00;
						stab_r <= sync2_r[gi];
					end else begin
						cnt_r  <= cnt_r + 8'h01;
					end
				end
				assign lvl[gi] = stab_r;
			end else begin : g_direct
				assign lvl[gi] = sync2_r[gi];
			end
		end
	endgenerate

	// -----------------------------------------------------------
	// Edge detection
	// -----------------------------------------------------------
	assign lvl_all = {sync2_r[17:16], lvl};
	assign rise    = lvl_all & ~prev_r;

	// Previous levels; a source high at reset release
	// shows as an event on the first cycles
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			prev_r <= '0;
		end else begin
			prev_r <= lvl_all;
		end
	end

	// -----------------------------------------------------------
	// Flag set and clear terms
	// -----------------------------------------------------------
	always_comb begin
		set_gpio = 16'h0000;
		// pin flag positions
		// Pin 6 edges count only while the pin is an input
		set_gpio[POS_PIN6_FLAG] = rise[17] & ~pin6_oe_r;
		set_gpio[POS_PIN5_FLAG] = rise[16];
		set_sys = rise[15:0] & SYS_FLAG_BITS;
		clr_gpio = (wr_i && hit(addr_i, ADDR_FLAGS_GPIO)) ?
			wdata_i : 16'h0000;
		clr_sys  = (wr_i && hit(addr_i, ADDR_FLAGS_SYS)) ?
			wdata_i : 16'h0000;
	end

	// -----------------------------------------------------------
	// Flag registers
	// -----------------------------------------------------------
	// A set in the same cycle as its clear wins, so no
	// event is lost to a racing acknowledge
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			st_gpio_r <= FLAGS_RST;
			st_sys_r  <= FLAGS_RST;
		end else begin
			st_gpio_r <= ((st_gpio_r & ~clr_gpio) | set_gpio)
				& GPIO_FLAG_BITS;
			st_sys_r  <= ((st_sys_r & ~clr_sys) | set_sys)
				& SYS_FLAG_BITS;
		end
	end

	// -----------------------------------------------------------
	// Mask, debounce and function registers
	// -----------------------------------------------------------
	// Masks reset to masked; spare system bits are kept
	// as written, the host is expected to leave them at one
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			mask_gpio_r <= MASK_GPIO_RST;
			mask_sys_r  <= MASK_SYS_RST;
		end else if (wr_i) begin
			if (hit(addr_i, ADDR_MASK_GPIO)) begin
				mask_gpio_r <= wdata_i & GPIO_FLAG_BITS;
			end
			if (hit(addr_i, ADDR_MASK_SYS)) begin
				mask_sys_r <= wdata_i;
			end
		end
	end
	// Debounce enables, on at reset
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			dben_r <= DB_EN_RST;
		end else if (wr_i && hit(addr_i, ADDR_DEBOUNCE)) begin
			dben_r <= wdata_i & DB_EN_BITS;
		end
	end
	// Pin 6 function select
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			fn_r <= FN_RST;
		end else if (wr_i && hit(addr_i, ADDR_PIN6_CFG)) begin
			fn_r <= wdata_i[4:0];
		end
	end

	// -----------------------------------------------------------
	// Interrupt output
	// -----------------------------------------------------------
	// unmasked flags raise request
	assign pend = |(st_gpio_r & ~mask_gpio_r) |
		|(st_sys_r & ~mask_sys_r);
	// Registered, so the request follows a flag by one cycle
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= pend;
		end
	end

	// -----------------------------------------------------------
	// Pin 6 routing
	// -----------------------------------------------------------
	// Reserved and unused codes leave the pin as an input
	always_comb begin
		p6_val = 1'b0;
		p6_oe  = 1'b1;
		case (fn_r)
			FN_IRQ:       p6_val = irq_r;
			FN_OVERHEAT:  p6_val = lvl[0];
			FN_PLL2:      p6_val = lvl[2];
			FN_PLL3:      p6_val = lvl[3];
			FN_FLL:       p6_val = lvl[5];
			FN_RANGE:     p6_val = lvl[6];
			FN_SEQ:       p6_val = lvl[7];
			FN_LVL_FIRST: p6_val = lvl[8];
			5'h0D:        p6_val = lvl[9];
			5'h0E:        p6_val = lvl[10];
			5'h0F:        p6_val = lvl[11];
			FN_LVL_LAST:  p6_val = lvl[12];
			FN_FIFO:      p6_val = lvl[13];
			FN_OUT_CLK:   p6_val = output_clock_i;
			FN_DMIC_CLK:  p6_val = dmic_clk_i;
			FN_DMIC_DATA: p6_oe  = 1'b0;
			FN_MIC_DET:   p6_val = lvl[14];
			FN_MIC_SHORT: p6_val = lvl[15];
			default:      p6_oe  = 1'b0;
		endcase
	end

	// Pin drivers and mic data, all from flip-flops
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			pin6_r    <= 1'b0;
			pin6_oe_r <= 1'b0;
			dmic_r    <= 1'b0;
		end else begin
			pin6_r    <= p6_val;
			pin6_oe_r <= p6_oe;
			dmic_r    <= (fn_r == FN_DMIC_DATA) & sync2_r[17];
		end
	end

	// -----------------------------------------------------------
	// Register read port
	// -----------------------------------------------------------
	// Unmapped addresses read zero
	always_comb begin
		rd_val = 16'h0000;
		case (addr_i)
			ADDR_PIN6_CFG:   rd_val = {11'h000, fn_r};
			ADDR_FLAGS_GPIO: rd_val = st_gpio_r;
			ADDR_FLAGS_SYS:  rd_val = st_sys_r;
			ADDR_MASK_GPIO:  rd_val = mask_gpio_r;
			ADDR_MASK_SYS:   rd_val = mask_sys_r;
			ADDR_DEBOUNCE:   rd_val = dben_r;
			default:         rd_val = 16'h0000;
		endcase
	end
	// Data stand for the one cycle after the strobe only
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rd_i ? rd_val : 16'h0000;
		end
	end
	assign rdata_o     = rdata_r;
	assign irq_o       = irq_r;
	assign pin6_o      = pin6_r;
	assign pin6_oe_o   = pin6_oe_r;
	assign dmic_data_o = dmic_r;

	// -----------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);

	// Set flags survive anything but a one written
	property p_w1c_hold;
		1 |=> ((st_sys_r & $past(st_sys_r & ~clr_sys))
			== $past(st_sys_r & ~clr_sys));
	endproperty
	a_w1c_hold: assert property (p_w1c_hold)
		else $error("system flag lost without clear");
	// Written one with no new event clears the bit
	property p_w1c_clear;
		(clr_sys[13] && !set_sys[13]) |=> !st_sys_r[13];
	endproperty
	a_w1c_clear: assert property (p_w1c_clear)
		else $error("fifo flag not cleared by write");
	property p_pin5_flag;
		rise[16] |=> st_gpio_r[4];
	endproperty
	a_pin5_flag: assert property (p_pin5_flag)
		else $error("pin 5 edge did not set bit 4");
	property p_mic_short;
		rise[15] |=> st_sys_r[15] ##1 (st_sys_r[15] ||
			$past(clr_sys[15]));
	endproperty
	a_mic_short: assert property (p_mic_short)
		else $error("mic short flag not at bit 15");
	property p_seq_done;
		$rose(lvl[7]) |=> st_sys_r[7];
	endproperty
	a_seq_done: assert property (p_seq_done)
		else $error("sequencer flag not at bit 7");
	property p_flags_zero_rst;
		$past(!nrst_i) |-> (st_sys_r == 16'h0000 &&
			st_gpio_r == 16'h0000 && mask_sys_r == 16'hFFFF);
	endproperty
	a_flags_zero_rst: assert property (p_flags_zero_rst)
		else $error("flag or mask wrong after reset");
	// Masked flags never reach the request line
	property p_mask_gates;
		((st_sys_r & ~mask_sys_r) == 16'h0000 &&
		 (st_gpio_r & ~mask_gpio_r) == 16'h0000) |=> !irq_o;
	endproperty
	a_mask_gates: assert property (p_mask_gates)
		else $error("request raised by masked flag");
	// Any unmasked flag, taken from the registers themselves
	property p_irq_follow;
		((st_sys_r & ~mask_sys_r) != 16'h0000 ||
		 (st_gpio_r & ~mask_gpio_r) != 16'h0000) |=> irq_o;
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("request late after unmasked flag");
	property p_pin6_seq;
		(fn_r == FN_SEQ) |=> (pin6_oe_o && pin6_o == $past(lvl[7]));
	endproperty
	a_pin6_seq: assert property (p_pin6_seq)
		else $error("pin 6 not driving sequencer done");
	property p_pin6_short;
		(fn_r == FN_MIC_SHORT) |=>
			(pin6_oe_o && pin6_o == $past(lvl[15]));
	endproperty
	a_pin6_short: assert property (p_pin6_short)
		else $error("pin 6 not driving mic short level");
	// Debounced lock rises only after ten steady cycles
	property p_debounce;
		($rose(lvl[5]) && $past(dben_r[5])) |->
			($past(sync2_r[5], 1) && $past(sync2_r[5], 10));
	endproperty
	a_debounce: assert property (p_debounce)
		else $error("lock level passed debounce early");
	c_irq_rise: cover property ($rose(irq_o));
	c_clear: cover property (clr_sys[0] && st_sys_r[0]);
	c_db_pass: cover property ($rose(lvl[5]) && dben_r[5]);
	c_race: cover property (clr_sys[13] && set_sys[13]);
endmodule

// >>> dv/host_model.sv
// Purpose: host processor side of the register port
// Assumes: one access at a time, strobes one cycle long
// Notes:   forces reserved system mask bits to one, never writes reserved pin codes
`timescale 1ns/100ps
module host_model
	import codec_irq_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic [15:0] rdata_i,
	output logic      [15:0] addr_o,
	output logic      [15:0] wdata_o,
	output logic             wr_o,
	output logic             rd_o
);
	// -----------------------------------------------------------
	// Idle bus at time zero
	// -----------------------------------------------------------
	initial begin
		addr_o  = 16'h0000;
		wdata_o = 16'h0000;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
	end

	// Write one word; the next call waits an edge, so no re-fire
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] v;
		v = d;
		if (a === ADDR_MASK_SYS) begin
			v = v | 16'h0012;
		end
		if (a === ADDR_PIN6_CFG && (d[4:0] >= 5'h17 ||
			d[4:0] == 5'h08 || d[4:0] == 5'h05 || d[4:0] == 5'h02)) begin
			return;
		end
		@(posedge clock_i);
		addr_o  <= a;
		wdata_o <= v;
		wr_o    <= 1'b1;
		@(posedge clock_i);
		wr_o    <= 1'b0;
	endtask

	// Read one word; data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
		@(posedge clock_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clock_i);
		rd_o   <= 1'b0;
		@(negedge clock_i);
		d = rdata_i;
	endtask
endmodule

// >>> dv/tb_top.sv
// Purpose: self-checking bench of the interrupt status block
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes:   events are held long enough to pass the debounce
`timescale 1ns/100ps
module tb_top;
	import codec_irq_pkg::*;
	logic        clk;          // System clock
	logic        nrst;         // Reset, active low
	logic [15:0] ev_v;         // Event source levels
	logic        pin5;         // Pin 5 level
	logic        pin6;         // Pin 6 input level
	logic        oclk;         // Output clock source
	logic        dclk;         // Mic clock source
	logic [15:0] addr;         // Host address
	logic [15:0] wdata;        // Host write data
	logic        wr;           // Host write strobe
	logic        rd;           // Host read strobe
	logic [15:0] rdata;        // Read data
	logic        p6_o;         // Pin 6 output
	logic        p6_oe;        // Pin 6 enable
	logic        dmic_d;       // Mic data out
	logic        irq;          // Interrupt request
	logic [15:0] lfsr_r;       // Random state
	logic [15:0] v;            // Scratch value
	int          errors;       // Mismatch count
	int          compares;     // Comparison count

	// -----------------------------------------------------------
	// Design and host
	// -----------------------------------------------------------
	codec_irq uut (.clock_i(clk), .nrst_i(nrst), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.events_i(sys_evt_t'(ev_v)), .pin5_i(pin5), .pin6_i(pin6),
		.pin6_o(p6_o), .pin6_oe_o(p6_oe), .output_clock_i(oclk),
		.dmic_clk_i(dclk), .dmic_data_o(dmic_d), .irq_o(irq));
	host_model host (.clock_i(clk), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	// Clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Fibonacci shift register for repeatable values
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Event bit that a pin 6 event code shows
	function automatic int code_bit(input logic [4:0] c);
		if (c <= FN_FIFO) begin
			return int'(c) - 4;
		end
		return (c == FN_MIC_DET) ? 14 : 15;
	endfunction

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rd_chk(logic [15:0] a, logic [15:0] e);
		logic [15:0] d;
		host.rd_reg(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask

	// Wait n edges, then settle at the falling edge
	task automatic wt(int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic stop_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog: the tests need well under 20000 cycles
	initial begin
		#2000000;
		errors++;
		stop_test();
	end

	// -----------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------
	initial begin
		{ev_v, pin5, pin6, oclk, dclk} = '0;
		nrst = 1'b0;
		errors = 0;
		compares = 0;
		lfsr_r = 16'hCABF;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		// Reset values and an unmapped read
		rd_chk(ADDR_FLAGS_GPIO, 16'h0000);
		rd_chk(ADDR_FLAGS_SYS, 16'h0000);
		rd_chk(ADDR_MASK_GPIO, 16'h0030);
		rd_chk(ADDR_MASK_SYS, 16'hFFFF);
		rd_chk(ADDR_DEBOUNCE, 16'h003F);
		rd_chk(ADDR_PIN6_CFG, 16'h0000);
		rd_chk(16'h0100, 16'h0000);
		chk("irq", 16'h0000, {15'h0000, irq});
		$display("reset test done");
		// Random mask contents read back
		for (int i = 0; i < 6; i++) begin
			lfsr_r = lfsr_next(lfsr_r);
			host.wr_reg(ADDR_MASK_SYS, lfsr_r);
			rd_chk(ADDR_MASK_SYS, lfsr_r | 16'h0012);
			host.wr_reg(ADDR_MASK_GPIO, lfsr_r);
			rd_chk(ADDR_MASK_GPIO, lfsr_r & 16'h0030);
		end
		host.wr_reg(ADDR_MASK_SYS, 16'hFFFF);
		host.wr_reg(ADDR_MASK_GPIO, 16'h0030);
		$display("mask test done");
		// Each system event: position, stickiness, mask, interrupt
		for (int b = 0; b < 16; b++) begin
			if (!SYS_FLAG_BITS[b]) continue;
			v = 16'h0001 << b;
			@(posedge clk) ev_v <= v;
			if (DB_SRC_BITS[b]) begin
				wt(3);
				rd_chk(ADDR_FLAGS_SYS, 16'h0000);
			end
			wt(20);
			rd_chk(ADDR_FLAGS_SYS, v);
			chk("irq masked", 16'h0000, {15'h0000, irq});
			host.wr_reg(ADDR_MASK_SYS, ~v);
			wt(3);
			chk("irq open", 16'h0001, {15'h0000, irq});
			@(posedge clk) ev_v <= 16'h0000;
			host.wr_reg(ADDR_FLAGS_SYS, ~v);
			rd_chk(ADDR_FLAGS_SYS, v);
			host.wr_reg(ADDR_FLAGS_SYS, v);
			wt(3);
			rd_chk(ADDR_FLAGS_SYS, 16'h0000);
			chk("irq clear", 16'h0000, {15'h0000, irq});
			host.wr_reg(ADDR_MASK_SYS, 16'hFFFF);
		end
		// Debounce off: the lock flag follows within a few cycles
		host.wr_reg(ADDR_DEBOUNCE, 16'h0000);
		rd_chk(ADDR_DEBOUNCE, 16'h0000);
		@(posedge clk) ev_v <= 16'h0020;
		wt(3);
		rd_chk(ADDR_FLAGS_SYS, 16'h0020);
		@(posedge clk) ev_v <= 16'h0000;
		host.wr_reg(ADDR_FLAGS_SYS, 16'hFFFF);
		host.wr_reg(ADDR_DEBOUNCE, 16'h003F);
		$display("event test done");
		// Pin flags in the first register
		@(posedge clk) pin5 <= 1'b1;
		wt(20);
		rd_chk(ADDR_FLAGS_GPIO, 16'h0010);
		@(posedge clk) pin6 <= 1'b1;
		wt(20);
		rd_chk(ADDR_FLAGS_GPIO, 16'h0030);
		// Unmasked pin flag reaches the request and pin 6
		host.wr_reg(ADDR_MASK_GPIO, 16'h0010);
		host.wr_reg(ADDR_PIN6_CFG, {11'h000, FN_IRQ});
		wt(4);
		chk("irq pin", 16'h0001, {15'h0000, irq});
		chk("pin6 irq", 16'h0003, {14'h0000, p6_oe, p6_o});
		// A driven pin 6 raises no flag of its own
		host.wr_reg(ADDR_FLAGS_GPIO, 16'h0030);
		@(posedge clk) pin6 <= 1'b0;
		wt(5);
		@(posedge clk) pin6 <= 1'b1;
		wt(5);
		rd_chk(ADDR_FLAGS_GPIO, 16'h0000);
		host.wr_reg(ADDR_MASK_GPIO, 16'h0030);
		host.wr_reg(ADDR_PIN6_CFG, 16'h0000);
		host.wr_reg(ADDR_FLAGS_GPIO, 16'h0030);
		wt(2);
		rd_chk(ADDR_FLAGS_GPIO, 16'h0000);
		$display("pin flag test done");
		// Event codes on pin 6
		for (int c = 4; c <= 22; c++) begin
			// Skip reserved codes, the clock routes and the mic data route
			if (c == 5 || c == 8 || (c >= 18 && c <= 20)) continue;
			host.wr_reg(ADDR_PIN6_CFG, 16'(c));
			host.wr_reg(ADDR_FLAGS_SYS, 16'hFFFF);
			wt(25);
			chk("pin6 low", 16'h0002, {14'h0000, p6_oe, p6_o});
			@(posedge clk) ev_v <= 16'h0001 << code_bit(5'(c));
			wt(25);
			chk("pin6 high", 16'h0003, {14'h0000, p6_oe, p6_o});
			@(posedge clk) ev_v <= 16'h0000;
		end
		// Clock routing codes
		host.wr_reg(ADDR_PIN6_CFG, {11'h000, FN_OUT_CLK});
		@(posedge clk) oclk <= 1'b1;
		wt(5);
		chk("out clock", 16'h0003, {14'h0000, p6_oe, p6_o});
		host.wr_reg(ADDR_PIN6_CFG, {11'h000, FN_DMIC_CLK});
		wt(5);
		chk("mic clock", 16'h0002, {14'h0000, p6_oe, p6_o});
		@(posedge clk) dclk <= 1'b1;
		wt(5);
		chk("mic clock", 16'h0003, {14'h0000, p6_oe, p6_o});
		// Mic data taken from the pin at random levels
		host.wr_reg(ADDR_PIN6_CFG, {11'h000, FN_DMIC_DATA});
		for (int i = 0; i < 8; i++) begin
			lfsr_r = lfsr_next(lfsr_r);
			@(posedge clk) pin6 <= lfsr_r[0];
			wt(5);
			chk("mic data", {14'h0000, 1'b0, lfsr_r[0]},
				{14'h0000, p6_oe, dmic_d});
		end
		$display("pin6 route test done");
		stop_test();
	end
endmodule
